/* File: hw/kbc_host_interface.sv */
// keyboard controller host port: output/input buffers, status, irq lines,
// core clock enable and program counter with reset and interrupt vectors
// assumes the host bus pins are asynchronous and the core runs on sys_clk_i
//
// Contract
// - select only at full addresses 60h and 64h
// - read 60h returns oldest unread firmware output byte
// - read 64h returns status, host cannot write
// - host write loads input buffer, SA2 to bit3
// - bit0 set on firmware write, host 60h read clears
// - bit1 set on host write, firmware read clears
// - core reads input buffer by dedicated instruction
// - bit2 firmware flag, clear or toggle
// - bits 7..4 loaded by firmware instruction
// - reset: controller disabled, powered down, pins on
// - leakage bit floats pins during power down
// - speed bit picks 8 or 12 MHz core
// - disabled controller floats both irq lines
// - enabled irq lines follow port2 bits 4, 5
// - per-line high-z bit floats, source forced one
// - 12-bit program counter spans 4K program memory
// - controller reset loads program counter 000h
// - input full interrupt calls address 003h
// - timer overflow interrupt calls address 007h

module kbc_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
  begin : g_bad
    $error("fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic push;
  logic pop;

  assign in_ready_o = (s_q.count != CW'(DEPTH));
  assign out_valid_o = (s_q.count != '0);
  assign out_data_o = s_q.mem[s_q.rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wr_ptr] = in_data_i;
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      s_d.rd_ptr = s_q.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      s_d.count = s_q.count + 1'b1;
    end
    else if (pop && !push)
    begin
      s_d.count = s_q.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule : kbc_byte_fifo

module kbc_host_interface
  import kbc_host_pkg::*;
#(
  parameter int CORE_PINS = 9,
  parameter int OBUF_DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // host bus pins
  input wire logic [15:0] sa_i,
  input wire logic aen_i,
  input wire logic ior_n_i,
  input wire logic iow_n_i,
  input wire logic [7:0] sd_i,
  output logic [7:0] sd_o,
  output logic sd_oe_o,
  // enable configuration register write
  input wire logic cfg_wr_i,
  input wire logic [5:0] cfg_data_i,
  output logic [5:0] cfg_o,
  // firmware: output buffer stream
  input wire logic fw_obuf_valid_i,
  input wire logic [7:0] fw_obuf_data_i,
  output logic fw_obuf_ready_o,
  // firmware: input buffer and status flags
  input wire logic fw_ibuf_rd_i,
  output logic [7:0] fw_ibuf_data_o,
  input wire logic fw_if0_clr_i,
  input wire logic fw_if0_tog_i,
  input wire logic fw_sts_wr_i,
  input wire logic [3:0] fw_sts_data_i,
  output logic [7:0] status_o,
  // core timing and program flow
  output logic core_clk_en_o,
  input wire logic pc_step_i,
  input wire logic pc_jump_i,
  input wire logic [11:0] pc_jump_addr_i,
  input wire logic ibf_irq_en_i,
  input wire logic tmr_irq_en_i,
  input wire logic tmr_ovf_i,
  input wire logic retr_i,
  output logic [11:0] pc_o,
  output logic irq_call_o,
  // irq sources and lines
  input wire logic port2_bit4_keyboard_irq_source_i,
  input wire logic port2_bit5_mouse_irq_source_i,
  output logic irq1_o,
  output logic irq1_oe_o,
  output logic irq12_o,
  output logic irq12_oe_o,
  // controller pins
  input wire logic [CORE_PINS-1:0] core_pin_oe_i,
  output logic [CORE_PINS-1:0] pin_oe_o
);

  if (CORE_PINS < 1 || PC_BITS != 12)
  begin : g_bad
    $error("unsupported pin count or program counter width");
  end

  typedef struct packed {
    isa_pins_t [2:0] sync;
    logic ior_n;
    logic iow_n;
    bus_state_t bus;
    logic [15:0] sa_lat;
    logic [7:0] sd_lat;
    logic [7:0] rd_data;
    logic sd_oe;
    logic [7:0] obuf;
    logic [7:0] ibuf;
    logic output_full_flag;
    logic input_full_flag;
    logic if0;
    logic f1;
    logic [3:0] gp;
    cfg_t cfg;
    logic [7:0] acc;
    logic core_en;
    logic [11:0] pc;
    logic in_service;
    logic tmr_pend;
    logic call;
    logic irq1;
    logic irq1_oe;
    logic irq12;
    logic irq12_oe;
    logic [CORE_PINS-1:0] pin_oe;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;

  // the fifo lets firmware queue bytes while the host is slow to read
  kbc_byte_fifo #(
    .WIDTH(8),
    .DEPTH(OBUF_DEPTH)
  ) u_obuf_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(fw_obuf_valid_i),
    .in_data_i(fw_obuf_data_i),
    .in_ready_o(fw_obuf_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  assign fifo_pop = fifo_valid && !s_q.output_full_flag;

  function automatic logic [7:0] pack_status(input state_t s);
    logic [7:0] v;
    v = 8'h00;
    v[ST_OBF] = s.output_full_flag;
    v[ST_IBF] = s.input_full_flag;
    v[ST_IF0] = s.if0;
    v[ST_F1] = s.f1;
    v[ST_GP_LSB +: GP_BITS] = s.gp;
    return v;
  endfunction : pack_status

  always_comb
  begin
    logic sel;
    logic host_rd_end;
    logic host_wr_end;
    logic [7:0] step;
    logic [7:0] sum;
    logic running;
    logic src1;
    logic src12;
    s_d = s_q;
    sel = 1'b0;
    host_rd_end = 1'b0;
    host_wr_end = 1'b0;
    step = 8'h00;
    sum = 8'h00;
    running = 1'b0;
    src1 = 1'b1;
    src12 = 1'b1;
    s_d.call = 1'b0;

    // three-stage pin sampling; a level counts once stages 2 and 3 agree
    s_d.sync[0] = '{ior_n: ior_n_i, iow_n: iow_n_i, aen: aen_i, sa: sa_i, sd: sd_i};
    s_d.sync[1] = s_q.sync[0];
    s_d.sync[2] = s_q.sync[1];
    if (s_q.sync[1].ior_n == s_q.sync[2].ior_n)
    begin
      s_d.ior_n = s_q.sync[2].ior_n;
    end
    if (s_q.sync[1].iow_n == s_q.sync[2].iow_n)
    begin
      s_d.iow_n = s_q.sync[2].iow_n;
    end

    // address enable high marks a dma cycle, never ours
    sel = !s_q.sync[2].aen && (s_q.sync[2].sa == ADDR_DATA || s_q.sync[2].sa == ADDR_CMD);

    case (s_q.bus)
      BUS_IDLE:
      begin
        // start on the agreed falling strobe so the byte is on the bus while it is low
        if (!s_d.ior_n && s_q.ior_n && sel)
        begin
          s_d.bus = BUS_READ;
          s_d.sa_lat = s_q.sync[2].sa;
          s_d.sd_oe = 1'b1;
          if (s_q.sync[2].sa[CMD_ADDR_BIT])
          begin
            s_d.rd_data = pack_status(s_q);
          end
          else
          begin
            s_d.rd_data = s_q.obuf;
          end
        end
        else if (!s_d.iow_n && s_q.iow_n && sel)
        begin
          s_d.bus = BUS_WRITE;
          s_d.sa_lat = s_q.sync[2].sa;
          s_d.sd_lat = s_q.sync[2].sd;
        end
      end
      BUS_READ:
      begin
        if (s_d.ior_n)
        begin
          s_d.bus = BUS_IDLE;
          s_d.sd_oe = 1'b0;
          host_rd_end = !s_q.sa_lat[CMD_ADDR_BIT];
        end
      end
      BUS_WRITE:
      begin
        // data is held while the strobe is low, the edge before the rise wins
        if (s_d.iow_n)
        begin
          s_d.bus = BUS_IDLE;
          host_wr_end = 1'b1;
        end
        else
        begin
          s_d.sd_lat = s_q.sync[2].sd;
        end
      end
      default:
      begin
        s_d.bus = BUS_IDLE;
        s_d.sd_oe = 1'b0;
      end
    endcase

    // status register write ports have no host path at all
    if (host_wr_end)
    begin
      s_d.ibuf = s_q.sd_lat;
      s_d.f1 = s_q.sa_lat[CMD_ADDR_BIT];
    end

    // set wins over clear for both full flags
    if (host_rd_end)
    begin
      s_d.output_full_flag = 1'b0;
    end
    if (fifo_pop)
    begin
      s_d.obuf = fifo_data;
      s_d.output_full_flag = 1'b1;
    end
    if (fw_ibuf_rd_i)
    begin
      s_d.input_full_flag = 1'b0;
    end
    if (host_wr_end)
    begin
      s_d.input_full_flag = 1'b1;
    end

    if (fw_if0_clr_i)
    begin
      s_d.if0 = 1'b0;
    end
    else if (fw_if0_tog_i)
    begin
      s_d.if0 = !s_q.if0;
    end
    if (fw_sts_wr_i)
    begin
      s_d.gp = fw_sts_data_i;
    end

    if (cfg_wr_i)
    begin
      s_d.cfg = cfg_t'(cfg_data_i);
    end

    // fractional divider: average rate is exact, single pulses jitter by one cycle
    running = s_q.cfg.enable && !s_q.cfg.power_down;
    step = s_q.cfg.speed_fast ? CORE_FAST_MHZ : CORE_SLOW_MHZ;
    sum = s_q.acc + step;
    s_d.core_en = 1'b0;
    if (running)
    begin
      if (sum >= SYS_CLK_MHZ)
      begin
        s_d.acc = sum - SYS_CLK_MHZ;
        s_d.core_en = 1'b1;
      end
      else
      begin
        s_d.acc = sum;
      end
    end
    else
    begin
      s_d.acc = 8'h00;
    end

    // program flow; the input-full call outranks a pending timer call
    if (tmr_ovf_i && tmr_irq_en_i)
    begin
      s_d.tmr_pend = 1'b1;
    end
    if (retr_i)
    begin
      s_d.in_service = 1'b0;
    end
    if (!running)
    begin
      s_d.pc = VEC_RESET;
      s_d.in_service = 1'b0;
      s_d.tmr_pend = 1'b0;
    end
    else if (s_q.core_en && !s_q.in_service && s_q.input_full_flag && ibf_irq_en_i)
    begin
      s_d.pc = VEC_IBF;
      s_d.in_service = 1'b1;
      s_d.call = 1'b1;
    end
    else if (s_q.core_en && !s_q.in_service && s_q.tmr_pend && tmr_irq_en_i)
    begin
      s_d.pc = VEC_TIMER;
      s_d.in_service = 1'b1;
      s_d.tmr_pend = 1'b0;
      s_d.call = 1'b1;
    end
    else if (pc_jump_i)
    begin
      s_d.pc = pc_jump_addr_i;
    end
    else if (pc_step_i)
    begin
      s_d.pc = s_q.pc + 12'h001;
    end

    // irq lines
    src1 = s_q.cfg.irq1_hiz ? 1'b1 : port2_bit4_keyboard_irq_source_i;
    src12 = s_q.cfg.irq12_hiz ? 1'b1 : port2_bit5_mouse_irq_source_i;
    s_d.irq1 = src1;
    s_d.irq12 = src12;
    s_d.irq1_oe = s_q.cfg.enable && !s_q.cfg.irq1_hiz;
    s_d.irq12_oe = s_q.cfg.enable && !s_q.cfg.irq12_hiz;

    if (s_q.cfg.power_down && s_q.cfg.leakage_ctrl)
    begin
      s_d.pin_oe = '0;
    end
    else
    begin
      s_d.pin_oe = core_pin_oe_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
      s_q.sync <= {PINS_IDLE, PINS_IDLE, PINS_IDLE};
      s_q.ior_n <= 1'b1;
      s_q.iow_n <= 1'b1;
      s_q.bus <= BUS_IDLE;
      s_q.cfg <= CFG_RESET;
      s_q.pc <= VEC_RESET;
      s_q.irq1 <= 1'b1;
      s_q.irq12 <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign sd_o = s_q.rd_data;
  assign sd_oe_o = s_q.sd_oe;
  assign cfg_o = s_q.cfg;
  assign fw_ibuf_data_o = s_q.ibuf;
  assign status_o = pack_status(s_q);
  assign core_clk_en_o = s_q.core_en;
  assign pc_o = s_q.pc;
  assign irq_call_o = s_q.call;
  assign irq1_o = s_q.irq1;
  assign irq1_oe_o = s_q.irq1_oe;
  assign irq12_o = s_q.irq12;
  assign irq12_oe_o = s_q.irq12_oe;
  assign pin_oe_o = s_q.pin_oe;

endmodule : kbc_host_interface

/* File: hw/kbc_host_pkg.sv */
// constants and types for the keyboard controller host interface
// assumes one 100 MHz clock with a synchronous active-high reset
package kbc_host_pkg;

  // host decode
  localparam logic [15:0] ADDR_DATA = 16'h0060;
  localparam logic [15:0] ADDR_CMD = 16'h0064;
  localparam int CMD_ADDR_BIT = 2;

  // status register bit positions
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_IF0 = 2;
  localparam int ST_F1 = 3;
  localparam int ST_GP_LSB = 4;
  localparam int GP_BITS = 4;

  // program counter
  localparam int PC_BITS = 12;
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_IBF = 12'h003;
  localparam logic [11:0] VEC_TIMER = 12'h007;

  // core clock enable, phase accumulator in MHz steps
  localparam logic [7:0] SYS_CLK_MHZ = 8'h64;
  localparam logic [7:0] CORE_SLOW_MHZ = 8'h08;
  localparam logic [7:0] CORE_FAST_MHZ = 8'h0c;

  // enable configuration register
  typedef struct packed {
    logic irq12_hiz;
    logic irq1_hiz;
    logic speed_fast;
    logic leakage_ctrl;
    logic power_down;
    logic enable;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{
    irq12_hiz: 1'b0,
    irq1_hiz: 1'b0,
    speed_fast: 1'b0,
    leakage_ctrl: 1'b0,
    power_down: 1'b1,
    enable: 1'b0
  };

  // one sample of the host bus pins
  typedef struct packed {
    logic ior_n;
    logic iow_n;
    logic aen;
    logic [15:0] sa;
    logic [7:0] sd;
  } isa_pins_t;

  localparam isa_pins_t PINS_IDLE = '{
    ior_n: 1'b1,
    iow_n: 1'b1,
    aen: 1'b1,
    sa: 16'h0000,
    sd: 8'h00
  };

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_READ,
    BUS_WRITE
  } bus_state_t;

endpackage : kbc_host_pkg

/* File: verification/kbc_host_sva.sv */
// checker for the keyboard controller host port
// assumes it is bound into kbc_host_interface, one clock domain
module kbc_host_sva #(
  parameter int CORE_PINS = 9
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic aen_i,
  input wire logic ior_n_i,
  input wire logic iow_n_i,
  input wire logic sd_oe_o,
  input wire logic [5:0] cfg_o,
  input wire logic fw_ibuf_rd_i,
  input wire logic fw_if0_clr_i,
  input wire logic fw_sts_wr_i,
  input wire logic [3:0] fw_sts_data_i,
  input wire logic [7:0] status_o,
  input wire logic core_clk_en_o,
  input wire logic [11:0] pc_o,
  input wire logic irq_call_o,
  input wire logic port2_bit4_keyboard_irq_source_i,
  input wire logic irq1_o,
  input wire logic irq1_oe_o,
  input wire logic irq12_oe_o,
  input wire logic [CORE_PINS-1:0] pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_dma_no_drive: assert property (aen_i [*8] |-> !sd_oe_o)
    else $error("data bus driven during dma");
  a_read_release: assert property (ior_n_i [*8] |-> !sd_oe_o)
    else $error("data bus held after read");
  a_ibf_fw_clear: assert property (
    iow_n_i [*8] ##0 fw_ibuf_rd_i |=> !status_o[1])
    else $error("input full not cleared");
  a_gp_flag_load: assert property (
    fw_sts_wr_i |=> status_o[7:4] == $past(fw_sts_data_i))
    else $error("general flags not loaded");
  a_if0_clear: assert property (fw_if0_clr_i |=> !status_o[2])
    else $error("firmware flag not cleared");
  a_reset_state: assert property (
    $fell(rst_i) |-> cfg_o == 6'h02 && pc_o == 12'h000)
    else $error("wrong state after reset");
  a_leak_float: assert property (
    cfg_o[1] && cfg_o[2] && $past(cfg_o[1] && cfg_o[2]) |-> pin_oe_o == '0)
    else $error("pins driven in leakage mode");
  a_off_quiet: assert property (
    !cfg_o[0] && $past(!cfg_o[0])
    |-> !irq1_oe_o && !irq12_oe_o && !core_clk_en_o && pc_o == 12'h000)
    else $error("disabled controller active");
  a_irq_follow: assert property (
    $stable(cfg_o) && cfg_o[0] && !cfg_o[4]
    |-> irq1_oe_o && irq1_o == $past(port2_bit4_keyboard_irq_source_i))
    else $error("keyboard irq not following source");
  a_irq_hiz: assert property ($stable(cfg_o) && cfg_o[4] |-> !irq1_oe_o && irq1_o)
    else $error("keyboard irq not floating");
  a_call_vector: assert property (
    irq_call_o |-> (pc_o == 12'h003 || pc_o == 12'h007) ##1 !irq_call_o)
    else $error("bad interrupt call");
endmodule : kbc_host_sva

bind kbc_host_interface kbc_host_sva #(.CORE_PINS(CORE_PINS)) u_kbc_host_sva (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .aen_i(aen_i), .ior_n_i(ior_n_i), .iow_n_i(iow_n_i),
  .sd_oe_o(sd_oe_o), .cfg_o(cfg_o), .fw_ibuf_rd_i(fw_ibuf_rd_i), .fw_if0_clr_i(fw_if0_clr_i),
  .fw_sts_wr_i(fw_sts_wr_i), .fw_sts_data_i(fw_sts_data_i), .status_o(status_o),
  .core_clk_en_o(core_clk_en_o), .pc_o(pc_o), .irq_call_o(irq_call_o),
  .port2_bit4_keyboard_irq_source_i(port2_bit4_keyboard_irq_source_i), .irq1_o(irq1_o),
  .irq1_oe_o(irq1_oe_o), .irq12_oe_o(irq12_oe_o), .pin_oe_o(pin_oe_o));

/* File: verification/kbc_host_bus_model.sv */
// host processor model: single byte i/o reads and writes
// assumes the bench calls cycle() and the port answers within the strobe
module kbc_host_bus_model
  import kbc_host_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // read answer
  input wire logic [7:0] bus_data_i,
  input wire logic bus_oe_i,
  // host pins
  output isa_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // strobe and recovery length, raised by the bench for a slow host
  int hold = 8;
  logic [7:0] rd_q;

  initial pins_o = PINS_IDLE;

  task automatic cycle(input logic wr, input logic dma, input logic [15:0] adr,
    input logic [7:0] wd);
    @(posedge sys_clk_i);
    pins_o.aen <= dma;
    pins_o.sa <= adr;
    pins_o.sd <= wr ? wd : ~pins_o.sd;
    @(posedge sys_clk_i);
    pins_o.iow_n <= !wr;
    pins_o.ior_n <= wr;
    repeat (hold) @(posedge sys_clk_i);
    rd_q = bus_oe_i ? bus_data_i : 8'hxx;
    pins_o.iow_n <= 1'b1;
    pins_o.ior_n <= 1'b1;
    repeat (hold) @(posedge sys_clk_i);
    // released bus must not keep the old byte
    pins_o.aen <= 1'b1;
    pins_o.sd <= ~pins_o.sd;
  endtask : cycle
endmodule : kbc_host_bus_model

/* File: verification/kbc_host_interface_tb.sv */
// self-checking bench for the keyboard controller host port
// assumes the host model drives the bus and firmware is played here
module kbc_host_interface_tb
  import kbc_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic dma;
    logic [15:0] adr;
    logic [7:0] wd;
    logic input_full_flag;
    logic f1;
    logic [7:0] ib;
  } row_t;

  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  isa_pins_t pins;
  logic sd_oe, cfg_wr, ob_valid, ob_ready, ib_rd, if0_clr, if0_tog, sts_wr, clk_en;
  logic step, ibf_en, tmr_en, ovf, retr, call, kb_src, ms_src;
  logic jump;
  logic [11:0] jump_adr;
  logic irq1, irq1_oe, irq12, irq12_oe;
  logic [7:0] sd, ob_data, ib_data, status;
  logic [5:0] cfg_d, cfg;
  logic [3:0] sts_d;
  logic [11:0] pc;
  logic [8:0] core_oe, pin_oe;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  row_t rows [6] = '{
    '{1'b0, 16'h0064, 8'ha5, 1'b1, 1'b1, 8'ha5},
    '{1'b0, 16'h0060, 8'h3c, 1'b1, 1'b0, 8'h3c},
    '{1'b0, 16'h0164, 8'h77, 1'b0, 1'b0, 8'h3c},
    '{1'b1, 16'h0060, 8'h55, 1'b0, 1'b0, 8'h3c},
    '{1'b0, 16'h0068, 8'h11, 1'b0, 1'b0, 8'h3c},
    '{1'b0, 16'h4064, 8'h0f, 1'b0, 1'b0, 8'h3c}
  };

  kbc_host_bus_model u_kbc_host_bus_model (.sys_clk_i(sys_clk_i), .bus_data_i(sd),
    .bus_oe_i(sd_oe), .pins_o(pins));

  kbc_host_interface u_kbc_host_interface (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sa_i(pins.sa), .aen_i(pins.aen),
    .ior_n_i(pins.ior_n), .iow_n_i(pins.iow_n), .sd_i(pins.sd), .sd_o(sd), .sd_oe_o(sd_oe),
    .cfg_wr_i(cfg_wr), .cfg_data_i(cfg_d), .cfg_o(cfg), .fw_obuf_valid_i(ob_valid),
    .fw_obuf_data_i(ob_data), .fw_obuf_ready_o(ob_ready), .fw_ibuf_rd_i(ib_rd),
    .fw_ibuf_data_o(ib_data), .fw_if0_clr_i(if0_clr), .fw_if0_tog_i(if0_tog),
    .fw_sts_wr_i(sts_wr), .fw_sts_data_i(sts_d), .status_o(status),
    .core_clk_en_o(clk_en), .pc_step_i(step), .pc_jump_i(jump), .pc_jump_addr_i(jump_adr),
    .ibf_irq_en_i(ibf_en), .tmr_irq_en_i(tmr_en), .tmr_ovf_i(ovf), .retr_i(retr),
    .pc_o(pc), .irq_call_o(call), .port2_bit4_keyboard_irq_source_i(kb_src),
    .port2_bit5_mouse_irq_source_i(ms_src), .irq1_o(irq1), .irq1_oe_o(irq1_oe),
    .irq12_o(irq12), .irq12_oe_o(irq12_oe), .core_pin_oe_i(core_oe), .pin_oe_o(pin_oe));

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  task automatic setcfg(input logic [5:0] v);
    @(posedge sys_clk_i);
    cfg_d <= v;
    cfg_wr <= 1'b1;
    @(posedge sys_clk_i);
    cfg_wr <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : setcfg

  task automatic count_en(output int m);
    m = 0;
    repeat (100)
    begin
      @(posedge sys_clk_i);
      m += clk_en;
    end
  endtask : count_en

  // the call pulse stands one cycle, so look after every edge
  task automatic wait_call(input logic [11:0] exp);
    int k;
    k = 0;
    while (call !== 1'b1 && k < 300)
    begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    check("call", 1'b1, call);
    check("call pc", exp, pc);
  endtask : wait_call

  initial
  begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_errors++;
      complete_run();
    end
  end

  initial
  begin
    {cfg_wr, ob_valid, ib_rd, if0_clr, if0_tog, sts_wr, step, ibf_en, tmr_en} = '0;
    {ovf, retr, kb_src, ms_src, ob_data, cfg_d, sts_d, jump, jump_adr} = '0;
    core_oe = 9'h1a5;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    foreach (rows[i])
    begin
      @(posedge sys_clk_i);
      ib_rd <= 1'b1;
      @(posedge sys_clk_i);
      ib_rd <= 1'b0;
      u_kbc_host_bus_model.cycle(1'b1, rows[i].dma, rows[i].adr, rows[i].wd);
      check("ibuf", rows[i].ib, ib_data);
      u_kbc_host_bus_model.cycle(1'b0, 1'b0, ADDR_CMD, 8'h00);
      n = {4'h0, rows[i].f1, 1'b0, rows[i].input_full_flag, 1'b0};
      check("status read", n, u_kbc_host_bus_model.rd_q);
      check("status", n, status);
      $display("row %0d done", i);
    end
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check("status", 8'h00, status);
    check("cfg", 6'h02, cfg);
    check("pins", 9'h1a5, pin_oe);
    check("pc", 12'h000, pc);
    check("irq oe", 2'b00, {irq1_oe, irq12_oe});
    $display("reset done");
    n = 0;
    @(posedge sys_clk_i);
    ob_valid <= 1'b1;
    ob_data <= 8'h80;
    repeat (20)
    begin
      @(posedge sys_clk_i);
      n += ob_ready;
      ob_data <= 8'h80 + n[7:0];
    end
    ob_valid <= 1'b0;
    check("accepted", 9, n);
    u_kbc_host_bus_model.cycle(1'b0, 1'b0, ADDR_CMD, 8'h00);
    check("status read", 8'h01, u_kbc_host_bus_model.rd_q);
    u_kbc_host_bus_model.hold = 12;
    for (int k = 0; k < 9; k++)
    begin
      check("obf", 1'b1, status[0]);
      u_kbc_host_bus_model.cycle(1'b0, 1'b0, ADDR_DATA, 8'h00);
      check("obuf", 8'h80 + k, u_kbc_host_bus_model.rd_q);
    end
    u_kbc_host_bus_model.hold = 8;
    check("obf", 1'b0, status[0]);
    $display("output buffer done");
    @(posedge sys_clk_i);
    sts_d <= 4'ha;
    sts_wr <= 1'b1;
    @(posedge sys_clk_i);
    sts_wr <= 1'b0;
    if0_tog <= 1'b1;
    @(posedge sys_clk_i);
    if0_tog <= 1'b0;
    @(posedge sys_clk_i);
    #1;
    check("status", 8'ha4, status);
    @(posedge sys_clk_i);
    if0_clr <= 1'b1;
    if0_tog <= 1'b1;
    @(posedge sys_clk_i);
    {if0_clr, if0_tog} <= 2'b00;
    @(posedge sys_clk_i);
    #1;
    check("status", 8'ha0, status);
    $display("flags done");
    @(posedge sys_clk_i);
    kb_src <= 1'b1;
    setcfg(6'h01);
    check("irq", 4'b1110, {irq1_oe, irq1, irq12_oe, irq12});
    count_en(n);
    check("slow rate", 8, n);
    // source drops so the follow property sees both levels
    kb_src <= 1'b0;
    setcfg(6'h09);
    check("irq", 4'b1010, {irq1_oe, irq1, irq12_oe, irq12});
    count_en(n);
    check("fast rate", 12, n);
    setcfg(6'h39);
    check("irq", 4'b0101, {irq1_oe, irq1, irq12_oe, irq12});
    setcfg(6'h06);
    check("irq oe", 2'b00, {irq1_oe, irq12_oe});
    check("pins", 9'h000, pin_oe);
    $display("config done");
    setcfg(6'h09);
    @(posedge sys_clk_i);
    ibf_en <= 1'b1;
    fork
      u_kbc_host_bus_model.cycle(1'b1, 1'b0, ADDR_DATA, 8'h42);
      wait_call(12'h003);
    join
    @(posedge sys_clk_i);
    {ibf_en, ib_rd, retr, tmr_en, ovf} <= 5'b01111;
    @(posedge sys_clk_i);
    {ib_rd, retr, ovf} <= 3'b000;
    wait_call(12'h007);
    // still in service, so no call can move the counter during the jump and step
    @(posedge sys_clk_i);
    jump_adr <= 12'hffe;
    jump <= 1'b1;
    @(posedge sys_clk_i);
    jump <= 1'b0;
    step <= 1'b1;
    @(posedge sys_clk_i);
    step <= 1'b0;
    #1;
    check("pc", 12'hfff, pc);
    setcfg(6'h00);
    check("pc", 12'h000, pc);
    $display("program flow done");
    complete_run();
  end
endmodule : kbc_host_interface_tb
